// ---- rtl/tmrc_defines.vh ----
// Constants for the timer output and reset control block.
// Assumes a 100 MHz ref_clk and a one-cycle pulse each second from outside.
// Operation
// RULE1 - Panel resets only in display mode, enabled
// RULE2 - Buttons held over three seconds reset timer
// RULE3 - Remote terminals held over one second reset
// RULE4 - Keep run-time total, viewable with two buttons
// RULE5 - Buttons held over ten seconds clear total
// RULE6 - Turn-on selection names one of five states
// RULE7 - Inverted turn-on means any other state
// RULE8 - Turn-off selection names one of five states
// RULE9 - Inverted turn-off means any other state
// RULE10 - On running, off not-running leaves running off
// RULE11 - Enable bit keeps selections and delay
// RULE12 - Turn-on delay in seconds, zero immediate
// RULE13 - On closes switch, off opens it
// RULE14 - Output one on lights first indicator
// RULE15 - Second output independent, same functions
// RULE16 - Output two on lights second indicator
// RULE17 - Hold counter restarts on release, fires once
// RULE18 - Off condition cancels pending turn-on
// RULE19 - Disabled output open and dark
`ifndef TMRC_DEFINES_VH
`define TMRC_DEFINES_VH
// Timer state codes
`define TMRC_ST_RESET 3'h0
`define TMRC_ST_RUN 3'h1
`define TMRC_ST_PAUSE 3'h2
`define TMRC_ST_RSTW 3'h3
`define TMRC_ST_DONE 3'h4
// Selection field: bit 3 inverts, bits 2:0 name a state
`define TMRC_SEL_INV 3
// Hold thresholds and turn-on delay limit in seconds
`define TMRC_PANEL_CLR_S 16'd3
`define TMRC_TOTAL_CLR_S 16'd10
`define TMRC_REMOTE_CLR_S 16'd1
`define TMRC_DELAY_MAX_S 16'd32400
// Register byte addresses
`define TMRC_A_CTRL 8'h00
`define TMRC_A_OUT1 8'h04
`define TMRC_A_OUT2 8'h08
`define TMRC_A_STAT 8'h0c
`define TMRC_A_TOTAL 8'h10
// Control bits
`define TMRC_C_PANEL_EN 0
`define TMRC_C_TOTAL_EN 1
`define TMRC_C_DISPLAY 2
// Output register fields
`define TMRC_O_EN 0
`define TMRC_O_ON_LSB 4
`define TMRC_O_OFF_LSB 8
`define TMRC_O_DLY_LSB 16
`endif

// ---- rtl/tmrc_output.v ----
// One solid-state control output with state matching and turn-on delay.
// Assumes sec_tick is a one-cycle pulse each second on ref_clk.
`timescale 1ns/1ps
`include "tmrc_defines.vh"
module tmrc_output (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Settings
  input wire enable,
  input wire [3:0] on_sel,
  input wire [3:0] off_sel,
  input wire [15:0] delay_s,
  // Timer
  input wire [2:0] timer_state,
  input wire sec_tick,
  // Switch drive
  output reg switch_closed
);
  reg [2:0] prev_state; // Last state, for entry detection
  reg pending; // Turn-on delay counting
  reg [15:0] dly_cnt; // Seconds waited
  wire entered;
  wire on_hit;
  wire off_hit;

  // Match a selection against a state, honouring the invert bit
  function sel_match;
    input [3:0] sel;
    input [2:0] st;
    begin
      sel_match = (sel[2:0] == st) ^ sel[`TMRC_SEL_INV]; // RULE6 RULE7 RULE8 RULE9
    end
  endfunction

  // Only an entry into a state acts, not dwelling in it
  assign entered = (timer_state != prev_state);
  assign on_hit = entered && sel_match(on_sel, timer_state);
  assign off_hit = entered && sel_match(off_sel, timer_state);

  // Off wins over on when both hit at one entry, so a running-only output drops at once
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_state <= `TMRC_ST_RESET;
      pending <= 1'b0;
      dly_cnt <= 16'h0000;
      switch_closed <= 1'b0;
    end else begin
      prev_state <= timer_state;
      if (!enable) begin
        pending <= 1'b0; // RULE11 RULE19
        switch_closed <= 1'b0; // RULE19
      end else if (off_hit) begin
        pending <= 1'b0; // RULE18 RULE10
        switch_closed <= 1'b0; // RULE13
      end else if (on_hit) begin
        if (delay_s == 16'h0000) begin
          switch_closed <= 1'b1; // RULE12 RULE13
        end else begin
          pending <= 1'b1; // RULE12
          dly_cnt <= 16'h0000;
        end
      end else if (pending && sec_tick) begin
        if (dly_cnt + 16'h0001 >= delay_s) begin
          pending <= 1'b0;
          switch_closed <= 1'b1; // RULE12
        end else begin
          dly_cnt <= dly_cnt + 16'h0001;
        end
      end
    end
  end
endmodule

// ---- rtl/tmrc_top.v ----
// Reset handling, run-time total and two control outputs behind AXI4-Lite.
// Assumes synchronous inputs and a one-second tick pulse from the time base.
`timescale 1ns/1ps
`include "tmrc_defines.vh"
module tmrc_top #(
  parameter TOTAL_W = 32
) (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Time base and timer
  input wire sec_tick,
  input wire [2:0] timer_state,
  // Operator buttons
  input wire btn_timer_a,
  input wire btn_timer_b,
  input wire btn_total_a,
  input wire btn_total_b,
  // Remote reset terminals, high while connected
  input wire remote_clear_terminal_a,
  input wire remote_clear_terminal_b,
  // Reset requests and total view
  output reg timer_clear,
  output reg total_view,
  // Switches and indicators
  output reg switch_one,
  output reg switch_two,
  output reg indicator_one,
  output reg indicator_two,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  reg [31:0] ctrl_reg; // Panel enables and display mode
  reg [31:0] out1_reg; // Output one settings
  reg [31:0] out2_reg; // Output two settings
  reg [TOTAL_W-1:0] total; // Accumulated run time in seconds
  reg [15:0] panel_cnt; // Timer-clear hold seconds
  reg [15:0] total_cnt; // Total-clear hold seconds
  reg [15:0] remote_cnt; // Remote hold seconds
  reg panel_done;
  reg total_done;
  reg remote_done;
  reg [7:0] aw_addr; // Latched write address
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  wire sw1;
  wire sw2;
  wire display_mode;
  wire panel_hold;
  wire total_hold;
  wire remote_hold;
  wire do_write;

  assign display_mode = ctrl_reg[`TMRC_C_DISPLAY];
  // Panel resets need display mode and their own enable
  assign panel_hold = btn_timer_a && btn_timer_b && display_mode && ctrl_reg[`TMRC_C_PANEL_EN]; // RULE1
  assign total_hold = btn_total_a && btn_total_b && display_mode && ctrl_reg[`TMRC_C_TOTAL_EN]; // RULE1
  // Remote terminals ignore the panel enable
  assign remote_hold = remote_clear_terminal_a && remote_clear_terminal_b; // RULE3

  // Merge write data into a register under byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  // Outputs share one module; settings are separate registers
  tmrc_output u_out1 (
    .ref_clk(ref_clk), .arst_n(arst_n), .enable(out1_reg[`TMRC_O_EN]),
    .on_sel(out1_reg[`TMRC_O_ON_LSB +: 4]), .off_sel(out1_reg[`TMRC_O_OFF_LSB +: 4]),
    .delay_s(out1_reg[`TMRC_O_DLY_LSB +: 16]), .timer_state(timer_state),
    .sec_tick(sec_tick), .switch_closed(sw1)
  );
  tmrc_output u_out2 (
    .ref_clk(ref_clk), .arst_n(arst_n), .enable(out2_reg[`TMRC_O_EN]),
    .on_sel(out2_reg[`TMRC_O_ON_LSB +: 4]), .off_sel(out2_reg[`TMRC_O_OFF_LSB +: 4]),
    .delay_s(out2_reg[`TMRC_O_DLY_LSB +: 16]), .timer_state(timer_state),
    .sec_tick(sec_tick), .switch_closed(sw2)
  ); // RULE15

  // Registered pin drive; indicator follows its switch
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_one <= 1'b0;
      switch_two <= 1'b0;
      indicator_one <= 1'b0;
      indicator_two <= 1'b0;
      total_view <= 1'b0;
    end else begin
      switch_one <= sw1; // RULE13
      switch_two <= sw2; // RULE13
      indicator_one <= sw1; // RULE14
      indicator_two <= sw2; // RULE16
      total_view <= btn_total_a && btn_total_b && display_mode; // RULE4
    end
  end

  // Hold counters restart on release and fire once per hold
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      panel_cnt <= 16'h0000;
      total_cnt <= 16'h0000;
      remote_cnt <= 16'h0000;
      panel_done <= 1'b0;
      total_done <= 1'b0;
      remote_done <= 1'b0;
      timer_clear <= 1'b0;
    end else begin
      timer_clear <= 1'b0;
      if (!panel_hold) begin
        panel_cnt <= 16'h0000; // RULE17
        panel_done <= 1'b0;
      end else if (sec_tick && !panel_done) begin
        if (panel_cnt >= `TMRC_PANEL_CLR_S) begin
          panel_done <= 1'b1; // RULE17
          timer_clear <= 1'b1; // RULE2
        end else begin
          panel_cnt <= panel_cnt + 16'h0001;
        end
      end
      if (!remote_hold) begin
        remote_cnt <= 16'h0000; // RULE17
        remote_done <= 1'b0;
      end else if (sec_tick && !remote_done) begin
        if (remote_cnt >= `TMRC_REMOTE_CLR_S) begin
          remote_done <= 1'b1;
          timer_clear <= 1'b1; // RULE3
        end else begin
          remote_cnt <= remote_cnt + 16'h0001;
        end
      end
      if (!total_hold) begin
        total_cnt <= 16'h0000; // RULE17
        total_done <= 1'b0;
      end else if (sec_tick && !total_done) begin
        if (total_cnt >= `TMRC_TOTAL_CLR_S) begin
          total_done <= 1'b1; // RULE5
        end else begin
          total_cnt <= total_cnt + 16'h0001;
        end
      end
    end
  end

  // Run-time total; a clear beats a tick in the same cycle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      total <= {TOTAL_W{1'b0}};
    end else if (total_hold && sec_tick && !total_done && total_cnt >= `TMRC_TOTAL_CLR_S) begin
      total <= {TOTAL_W{1'b0}}; // RULE5
    end else if (sec_tick && timer_state == `TMRC_ST_RUN) begin
      total <= total + {{(TOTAL_W-1){1'b0}}, 1'b1}; // RULE4
    end
  end

  assign do_write = aw_have && w_have && !s_axi_bvalid;

  // Write channels taken in either order, answer once both are held
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_reg <= 32'h00000000;
      out1_reg <= 32'h00000000;
      out2_reg <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready;
      s_axi_wready <= !w_have && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `TMRC_A_CTRL: ctrl_reg <= merge(ctrl_reg, w_data, w_strb) & 32'h00000007;
          // Both invert bits (7 and 11) are kept so inverted selections reach the outputs
          `TMRC_A_OUT1: out1_reg <= merge(out1_reg, w_data, w_strb) & 32'hffff0ff1; // RULE11 RULE7
          `TMRC_A_OUT2: out2_reg <= merge(out2_reg, w_data, w_strb) & 32'hffff0ff1; // RULE15
          `TMRC_A_STAT, `TMRC_A_TOTAL: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; status shows timer state, the panel and remote hold-done flags and the switch states ahead of the pins
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `TMRC_A_CTRL: s_axi_rdata <= ctrl_reg;
          `TMRC_A_OUT1: s_axi_rdata <= out1_reg;
          `TMRC_A_OUT2: s_axi_rdata <= out2_reg;
          `TMRC_A_STAT: s_axi_rdata <= {25'h0, timer_state, panel_done, remote_done, sw2, sw1};
          `TMRC_A_TOTAL: s_axi_rdata <= total;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/tb_tmrc_top.sv ----
// Self-checking bench for tmrc_top over AXI4-Lite and field inputs.
// Assumes the field model supplies the tick and the button pairs.
`timescale 1ns/1ps
`include "tmrc_defines.vh"
module tb_tmrc_top;
  // Clock, reset and timer state
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [2:0] timer_state = 3'h0;
  // Bus master side
  reg [7:0] s_axi_awaddr = 8'h00;
  reg [7:0] s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // Field side and outputs
  wire sec_tick, btn_timer_a, btn_timer_b, btn_total_a, btn_total_b;
  wire remote_clear_terminal_a, remote_clear_terminal_b;
  wire timer_clear, total_view, switch_one, switch_two, indicator_one, indicator_two;
  // Counters and read results
  integer fail_count = 0, num_checks = 0, clr_n = 0, base, s;
  reg [31:0] rd;
  always #5 ref_clk = ~ref_clk;
  tmrc_field #(.TICK(20)) fld (.ref_clk, .sec_tick, .btn_timer_a, .btn_timer_b, .btn_total_a,
    .btn_total_b, .remote_clear_terminal_a, .remote_clear_terminal_b);
  tmrc_top dut_u (.ref_clk, .arst_n, .sec_tick, .timer_state, .btn_timer_a, .btn_timer_b, .btn_total_a,
    .btn_total_b, .remote_clear_terminal_a, .remote_clear_terminal_b, .timer_clear, .total_view,
    .switch_one, .switch_two, .indicator_one, .indicator_two, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Count clear pulses; each hold checks the number it added, zero or one
  always @(posedge ref_clk) if (timer_clear === 1'b1) clr_n <= clr_n + 1;
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  endtask
  // Both channels offered together, each released once taken
  task axw(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Every write here goes to a mapped register, so the response is OKAY
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task axr(input [7:0] a, input [31:0] e, input [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(rd, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  // Wait whole ticks, then let the registered outputs settle
  task ticks(input integer n);
    repeat (n) @(posedge sec_tick);
    repeat (3) @(posedge ref_clk);
  endtask
  task go(input [2:0] st);
    @(posedge ref_clk);
    timer_state <= st;
    repeat (3) @(posedge ref_clk);
  endtask
  // Hold one pair for n ticks and count the clears it caused
  task hold(input [1:0] w, input integer n, input integer e);
    base = clr_n;
    fld.press(w);
    ticks(n);
    fld.press(2'h3);
    repeat (3) @(posedge ref_clk);
    chk(clr_n - base, e);
  endtask
  task finish_test;
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    axr(8'h20, 32'h0, 2'h2);
    axw(`TMRC_A_CTRL, 32'h5);
    hold(2'h0, 3, 0);
    hold(2'h0, 4, 1);
    axw(`TMRC_A_CTRL, 32'h4);
    hold(2'h0, 5, 0);
    axw(`TMRC_A_CTRL, 32'h1);
    hold(2'h0, 5, 0);
    hold(2'h2, 1, 0);
    hold(2'h2, 2, 1);
    // Five seconds of running, then view and clear the total
    // Start just after a tick so no tick slips in before ticks() begins counting
    @(posedge sec_tick);
    go(`TMRC_ST_RUN);
    ticks(5);
    go(`TMRC_ST_RESET);
    axw(`TMRC_A_CTRL, 32'h6);
    fld.press(2'h1);
    ticks(10);
    chk(total_view, 1);
    axr(`TMRC_A_TOTAL, 32'h5, 2'h0);
    ticks(1);
    fld.press(2'h3);
    axr(`TMRC_A_TOTAL, 32'h0, 2'h0);
    // Every state as turn-on, the next one as turn-off
    for (s = 0; s < 5; s = s + 1) begin
      axw(`TMRC_A_OUT1, 32'h1 | (32'(s) << 4) | (32'((s + 1) % 5) << 8));
      go(3'((s + 1) % 5));
      chk(switch_one, 0);
      go(3'(s));
      chk({switch_one, indicator_one}, 2'h3);
      go(3'((s + 1) % 5));
      chk(switch_one, 0);
    end
    axw(`TMRC_A_OUT1, 32'h1a1);
    go(`TMRC_ST_RUN);
    go(`TMRC_ST_DONE);
    chk(switch_one, 1);
    axw(`TMRC_A_OUT1, 32'h911);
    go(`TMRC_ST_RUN);
    chk(switch_one, 1);
    go(`TMRC_ST_RSTW);
    chk(switch_one, 0);
    go(`TMRC_ST_RUN);
    axw(`TMRC_A_OUT1, 32'h910);
    // Disable reaches the pins two edges after the write lands
    repeat (2) @(posedge ref_clk);
    chk({switch_one, indicator_one}, 2'h0);
    axr(`TMRC_A_OUT1, 32'h910, 2'h0);
    // Second output with a two-second delay, then a cancelled turn-on
    axw(`TMRC_A_OUT2, 32'h20211);
    go(`TMRC_ST_DONE);
    // Enter running just after a tick so the delay count starts from a known phase
    @(posedge sec_tick);
    go(`TMRC_ST_RUN);
    ticks(1);
    chk(switch_two, 0);
    ticks(1);
    chk({switch_two, indicator_two}, 2'h3);
    // Status: running state, output two closed, output one disabled
    axr(`TMRC_A_STAT, 32'h12, 2'h0);
    axw(`TMRC_A_OUT2, 32'h30211);
    go(`TMRC_ST_PAUSE);
    go(`TMRC_ST_RUN);
    ticks(1);
    go(`TMRC_ST_PAUSE);
    ticks(3);
    chk(switch_two, 0);
    finish_test;
  end
  // Whole run needs about 1000 cycles
  initial begin
    #200000;
    fail_count = fail_count + 1;
    finish_test;
  end
endmodule

// ---- verification/tmrc_chk_sva.sv ----
// Concurrent checks on the ports of tmrc_top.
// Assumes one clock domain; bound to every tmrc_top instance.
`timescale 1ns/1ps
module tmrc_chk (
  // Clock and reset
  input wire ref_clk,
  input wire arst_n,
  // Time base and field inputs
  input wire sec_tick,
  input wire btn_timer_a,
  input wire btn_timer_b,
  input wire btn_total_a,
  input wire btn_total_b,
  input wire remote_clear_terminal_a,
  input wire remote_clear_terminal_b,
  // Block outputs
  input wire timer_clear,
  input wire total_view,
  input wire switch_one,
  input wire switch_two,
  input wire indicator_one,
  input wire indicator_two,
  // Bus handshakes
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_arready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ind_one_a: assert property (indicator_one == switch_one)
    else $error("Indicator one differs from switch one");
  ind_two_a: assert property (indicator_two == switch_two)
    else $error("Indicator two differs from switch two");
  // A hold fires once, so the request is never two cycles long
  clr_pulse_a: assert property (timer_clear |=> !timer_clear)
    else $error("Timer clear longer than one cycle");
  clr_cause_a: assert property (timer_clear |-> $past(sec_tick) &&
    ($past(btn_timer_a && btn_timer_b) || $past(remote_clear_terminal_a && remote_clear_terminal_b)))
    else $error("Timer clear without a held pair on a tick");
  view_cause_a: assert property (total_view |-> $past(btn_total_a && btn_total_b))
    else $error("Total view without both buttons");
  bdrop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response not released");
  rdrop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data not released");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while data pending");
endmodule
bind tmrc_top tmrc_chk u_chk (.ref_clk, .arst_n, .sec_tick, .btn_timer_a, .btn_timer_b, .btn_total_a,
  .btn_total_b, .remote_clear_terminal_a, .remote_clear_terminal_b, .timer_clear, .total_view,
  .switch_one, .switch_two, .indicator_one, .indicator_two, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_arready);

// ---- verification/tmrc_field.sv ----
// Operator buttons, remote terminals and a compressed time base.
// Assumes the bench calls press from one process only.
`timescale 1ns/1ps
module tmrc_field #(
  parameter TICK = 20
) (
  // Clock
  input wire ref_clk,
  // Time base
  output reg sec_tick,
  // Buttons and terminals, high while closed
  output reg btn_timer_a,
  output reg btn_timer_b,
  output reg btn_total_a,
  output reg btn_total_b,
  output reg remote_clear_terminal_a,
  output reg remote_clear_terminal_b
);
  // Cycle within one compressed second
  integer cyc = 0;
  // Everything open at start; contacts idle open, not floating
  initial begin
    sec_tick = 1'b0;
    press(2'h3);
  end
  // A short second keeps multi-second holds cheap to simulate
  always @(posedge ref_clk) begin
    cyc <= (cyc == TICK - 1) ? 0 : cyc + 1;
    sec_tick <= (cyc == TICK - 1);
  end
  // Close one pair: 0 timer buttons, 1 total buttons, 2 terminals, 3 none
  task press(input [1:0] w);
    @(posedge ref_clk);
    btn_timer_a <= (w == 2'h0);
    btn_timer_b <= (w == 2'h0);
    btn_total_a <= (w == 2'h1);
    btn_total_b <= (w == 2'h1);
    remote_clear_terminal_a <= (w == 2'h2);
    remote_clear_terminal_b <= (w == 2'h2);
  endtask
endmodule
